/* design/pcl_cfg.svh */
// Offsets, field positions, reset values and timing counts of the parallel loader
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH

// Register byte offsets
`define PCL_OFF_CTRL          12'h000
`define PCL_OFF_LEN           12'h004
`define PCL_OFF_STAT          12'h008
`define PCL_OFF_COUNT         12'h00C
`define PCL_OFF_CHECK         12'h010

// Control register fields
`define PCL_CTRL_WIDTH_LSB    0
`define PCL_CTRL_RATIO_LSB    2
`define PCL_CTRL_USRCLK_BIT   6

// Reset values
`define PCL_CTRL_RST          32'h0000_0008
`define PCL_LEN_RST           32'h0000_0400

// Option bit position inside the first image word
`define PCL_OPT_INITDONE_BIT  0

// Data width codes
`define PCL_WIDTH_8           2'h0
`define PCL_WIDTH_16          2'h1

// Clock rate and documented times
`define PCL_CLK_MHZ           200
`define PCL_T_POR_US          100
`define PCL_T_STATUS_MIN_US   268
`define PCL_T_STATUS_MAX_US   1506
`define PCL_T_INIT_OSC_US     175
`define PCL_T_CONFIG_CLOCK_MAX_NS     10
`define PCL_USR_INIT_PERIODS  8576

// Derived cycle counts (least times round up)
`define PCL_POR_CYC        (`PCL_T_POR_US * `PCL_CLK_MHZ)
`define PCL_STATUS_MIN_CYC (`PCL_T_STATUS_MIN_US * `PCL_CLK_MHZ)
`define PCL_STATUS_MAX_CYC (`PCL_T_STATUS_MAX_US * `PCL_CLK_MHZ)
`define PCL_INIT_OSC_CYC   (`PCL_T_INIT_OSC_US * `PCL_CLK_MHZ)
`define PCL_USR_WAIT_CYC   ((4 * `PCL_T_CONFIG_CLOCK_MAX_NS * `PCL_CLK_MHZ + 999) / 1000)

`endif

/* design/pcl_pkg.sv */
// Types shared by the parallel configuration loader
package pcl_pkg;
   typedef enum logic [3:0] {
      PCL_POR, PCL_RESET, PCL_STATUS_HOLD, PCL_LOAD,
      PCL_DONE_WAIT, PCL_INIT, PCL_USER, PCL_ERROR
   } pcl_state_e;
   typedef logic [31:0] pcl_word_t;
   typedef logic [11:0] pcl_addr_t;
endpackage

/* design/pcl_sync.sv */
// Two-flop synchroniser with edge detection on the settled level
`timescale 1ns/10ps
module pcl_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Asynchronous inputs
   input  wire logic [WIDTH-1:0] d_in,
   // Settled level and edges
   output logic      [WIDTH-1:0] q_out,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);
   logic [WIDTH-1:0] meta_reg;  // First flop, read only by second
   logic [WIDTH-1:0] sync_reg;  // Settled level
   logic [WIDTH-1:0] last_reg;  // Previous settled level

   if (WIDTH < 1) begin : g_bad_width
      $error("pcl_sync width must be at least one");
   end

   // Two-flop chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= RESET_VAL;
         sync_reg <= RESET_VAL;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   // Delayed copy for edge finding
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= RESET_VAL;
      end else begin
         last_reg <= sync_reg;
      end
   end

   assign q_out = sync_reg;
   assign rise  = sync_reg & ~last_reg;
   assign fall  = ~sync_reg & last_reg;
endmodule // pcl_sync

/* design/pcl_loader.sv */
// Parallel configuration loader, ratio above one, with APB control
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/10ps
`include "pcl_cfg.svh"

module pcl_loader #(
   parameter int POR_CYCLES        = `PCL_POR_CYC,
   parameter int STATUS_MIN_CYCLES = `PCL_STATUS_MIN_CYC,
   parameter int STATUS_MAX_CYCLES = `PCL_STATUS_MAX_CYC,
   parameter int INIT_OSC_CYCLES   = `PCL_INIT_OSC_CYC,
   parameter int USR_INIT_EDGES    = `PCL_USR_INIT_PERIODS
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire pcl_pkg::pcl_addr_t paddr,
   input  wire pcl_pkg::pcl_word_t pwdata,
   output pcl_pkg::pcl_word_t      prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Configuration handshake pins
   input  wire logic               config_request_n,
   input  wire logic               config_status_n_i,
   output logic                    config_status_n_o,
   output logic                    config_status_n_oe,
   output logic                    load_complete,
   // Configuration data pins
   input  wire logic               config_clock,
   input  wire pcl_pkg::pcl_word_t config_data,
   // Initialisation
   input  wire logic               init_user_clock,
   output logic                    init_done_n,
   output logic                    user_mode
);
   import pcl_pkg::*;

   // Cycle limits at counter width
   localparam logic [31:0] L_POR  = 32'(POR_CYCLES);
   localparam logic [31:0] L_SMIN = 32'(STATUS_MIN_CYCLES);
   localparam logic [31:0] L_SMAX = 32'(STATUS_MAX_CYCLES);
   localparam logic [31:0] L_OSC  = 32'(INIT_OSC_CYCLES);
   localparam logic [31:0] L_UW   = 32'(`PCL_USR_WAIT_CYC);
   localparam logic [13:0] L_UEND = 14'(USR_INIT_EDGES - 1);

   // Parameter sanity
   if (POR_CYCLES < 1 || STATUS_MIN_CYCLES < 1 || INIT_OSC_CYCLES < 1 ||
       STATUS_MAX_CYCLES < STATUS_MIN_CYCLES || USR_INIT_EDGES < 1 ||
       USR_INIT_EDGES > 16384) begin : g_bad_param
      $error("pcl_loader parameters out of range");
   end

   // Decode the ratio field; values below two are lifted to two
   function automatic logic [3:0] ratio_of(input pcl_word_t c);
      logic [3:0] r;
      r = c[`PCL_CTRL_RATIO_LSB +: 4];
      return (r < 4'h2) ? 4'h2 : r;
   endfunction

   // Mask a bus word to the selected width
   function automatic pcl_word_t mask_of(input pcl_word_t c, input pcl_word_t d);
      logic [1:0] w;
      w = c[`PCL_CTRL_WIDTH_LSB +: 2];
      if (w == `PCL_WIDTH_8) begin
         return {24'h00_0000, d[7:0]};
      end else if (w == `PCL_WIDTH_16) begin
         return {16'h0000, d[15:0]};
      end
      return d;
   endfunction

   // Synchronised pins
   logic [3:0]  pin_q;         // Settled levels
   logic [3:0]  pin_rise;      // Rising edges
   logic [3:0]  pin_fall;      // Falling edges
   pcl_word_t   data_q;        // Settled data bus
   logic        req_s;         // Request level
   logic        stat_in_s;     // Status line level
   logic        clk_rise;      // Config clock rising
   logic        clk_fall;      // Config clock falling
   logic        usr_rise;      // User init clock rising

   // Control state
   pcl_state_e  state_reg;     // Current state
   pcl_state_e  state_next;    // Next state
   logic [31:0] cnt_reg;       // Cycles in present phase
   logic [3:0]  phase_reg;     // Edge phase inside a word
   logic [1:0]  fall_cnt_reg;  // Falling edges after load
   logic [13:0] usr_cnt_reg;   // User clock periods counted
   pcl_word_t   word_cnt_reg;  // Words accepted
   pcl_word_t   chk_reg;       // Running check of image
   logic        opt_reg;       // Init-done option loaded
   logic        err_reg;       // Image error seen
   logic        accept;        // Word taken this cycle
   pcl_word_t   word_in;       // Masked incoming word

   // Software registers
   pcl_word_t   ctrl_reg;      // Width, ratio, init clock choice
   pcl_word_t   len_reg;       // Image length in words
   logic        usr_sel;       // Use the user init clock

   // Pin order: user clock, config clock, status, request
   pcl_sync #(
      .WIDTH     (4),
      .RESET_VAL (4'b0011)
   ) u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_in    ({init_user_clock, config_clock, config_status_n_i, config_request_n}),
      .q_out   (pin_q),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   // Data bus; edges unused
   pcl_sync #(
      .WIDTH     (32),
      .RESET_VAL (32'h0000_0000)
   ) u_data_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d_in    (config_data),
      .q_out   (data_q),
      .rise    (),
      .fall    ()
   );

   assign req_s     = pin_q[0];
   assign stat_in_s = pin_q[1];
   assign clk_rise  = pin_rise[2];
   assign clk_fall  = pin_fall[2];
   assign usr_rise  = pin_rise[3];
   assign usr_sel   = ctrl_reg[`PCL_CTRL_USRCLK_BIT];
   assign word_in   = mask_of(ctrl_reg, data_q);
   // Clock and data share the same sync depth, so the word seen is the edge's
   assign accept    = (state_reg == PCL_LOAD) && clk_rise && stat_in_s &&
                      (phase_reg == 4'h0);

   // Next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PCL_POR: begin
            if (cnt_reg >= L_POR - 32'h0000_0001) begin
               state_next = PCL_LOAD;
            end
         end
         PCL_RESET: begin
            if (req_s) begin
               state_next = PCL_STATUS_HOLD;
            end
         end
         PCL_STATUS_HOLD: begin
            // Release after the least pulse; the host may still hold it
            if (cnt_reg >= L_SMIN - 32'h0000_0001) begin
               state_next = PCL_LOAD;
            end
         end
         PCL_LOAD: begin
            if (accept && (word_cnt_reg + 32'h0000_0001 == len_reg)) begin
               // Image good only if the check folds to zero
               state_next = ((chk_reg ^ word_in) == 32'h0000_0000) ?
                            PCL_DONE_WAIT : PCL_ERROR;
            end
         end
         PCL_DONE_WAIT: begin
            if (clk_fall && fall_cnt_reg == 2'h1) begin
               state_next = PCL_INIT;
            end
         end
         PCL_INIT: begin
            if (usr_sel) begin
               if (usr_rise && usr_cnt_reg == L_UEND && cnt_reg >= L_UW) begin
                  state_next = PCL_USER;
               end
            end else if (cnt_reg >= L_OSC - 32'h0000_0001) begin
               state_next = PCL_USER;
            end
         end
         PCL_USER: begin
            state_next = PCL_USER;
         end
         PCL_ERROR: begin
            state_next = PCL_ERROR;
         end
      endcase
      // Request low wins over all but power-on
      if (!req_s && state_reg != PCL_POR) begin
         state_next = PCL_RESET;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= PCL_POR;
      end else begin
         state_reg <= state_next;
      end
   end

   // Phase counter; keeps running from load-complete into init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 32'h0000_0000;
      end else if (state_next != state_reg && state_reg != PCL_DONE_WAIT) begin
         cnt_reg <= 32'h0000_0000;
      end else begin
         cnt_reg <= cnt_reg + 32'h0000_0001;
      end
   end

   // Edge phase; intervening edges are counted but take no word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 4'h0;
      end else if (state_reg != PCL_LOAD) begin
         phase_reg <= 4'h0;
      end else if (clk_rise && stat_in_s) begin
         phase_reg <= (phase_reg == ratio_of(ctrl_reg) - 4'h1) ?
                      4'h0 : phase_reg + 4'h1;
      end
   end

   // Word count, check and option capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_cnt_reg <= 32'h0000_0000;
         chk_reg      <= 32'h0000_0000;
         opt_reg      <= 1'b0;
      end else if (state_reg == PCL_RESET) begin
         word_cnt_reg <= 32'h0000_0000;
         chk_reg      <= 32'h0000_0000;
         opt_reg      <= 1'b0;
      end else if (accept) begin
         word_cnt_reg <= word_cnt_reg + 32'h0000_0001;
         chk_reg      <= chk_reg ^ word_in;
         if (word_cnt_reg == 32'h0000_0000) begin
            opt_reg <= word_in[`PCL_OPT_INITDONE_BIT];
         end
      end
   end

   // Falling edges after load-complete and user clock periods
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fall_cnt_reg <= 2'h0;
         usr_cnt_reg  <= 14'h0000;
      end else if (state_reg != PCL_DONE_WAIT && state_reg != PCL_INIT) begin
         fall_cnt_reg <= 2'h0;
         usr_cnt_reg  <= 14'h0000;
      end else begin
         if (state_reg == PCL_DONE_WAIT && clk_fall) begin
            fall_cnt_reg <= fall_cnt_reg + 2'h1;
         end
         // User clock is only heeded after the enable delay
         if (state_reg == PCL_INIT && usr_sel && usr_rise && cnt_reg >= L_UW) begin
            usr_cnt_reg <= usr_cnt_reg + 14'h0001;
         end
      end
   end

   // Error flag; a new request clears it, entry into error wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_reg <= 1'b0;
      end else if (state_next == PCL_ERROR) begin
         err_reg <= 1'b1;
      end else if (state_reg == PCL_RESET) begin
         err_reg <= 1'b0;
      end
   end

   // Pin outputs, registered from the next state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_status_n_o  <= 1'b0;
         config_status_n_oe <= 1'b1;
         load_complete      <= 1'b0;
         init_done_n        <= 1'b1;
         user_mode          <= 1'b0;
      end else begin
         config_status_n_o  <= 1'b0;  // Open drain: drive low only
         config_status_n_oe <= (state_next == PCL_POR) || (state_next == PCL_RESET) ||
                               (state_next == PCL_STATUS_HOLD) ||
                               (state_next == PCL_ERROR);
         load_complete      <= (state_next == PCL_DONE_WAIT) ||
                               (state_next == PCL_INIT) ||
                               (state_next == PCL_USER);
         init_done_n        <= !(opt_reg && state_next != PCL_USER &&
                                 state_next != PCL_RESET);
         user_mode          <= (state_next == PCL_USER);
      end
   end

   // APB: one wait state, answer in the cycle after setup's access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         unique case (paddr)
            `PCL_OFF_CTRL:  prdata <= ctrl_reg;
            `PCL_OFF_LEN:   prdata <= len_reg;
            `PCL_OFF_STAT:  prdata <= {22'h00_0000, state_reg, err_reg, opt_reg,
                                       user_mode, load_complete,
                                       !config_status_n_oe, stat_in_s};
            `PCL_OFF_COUNT: prdata <= word_cnt_reg;
            `PCL_OFF_CHECK: prdata <= chk_reg;
            default:        pslverr <= 1'b1;  // Unmapped address
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Writable registers take effect at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `PCL_CTRL_RST;
         len_reg  <= `PCL_LEN_RST;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `PCL_OFF_CTRL) begin
            ctrl_reg <= {25'h000_0000, pwdata[6:0]};
         end
         if (paddr == `PCL_OFF_LEN) begin
            // Zero length would never complete; held at one
            len_reg <= (pwdata == 32'h0000_0000) ? 32'h0000_0001 : pwdata;
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_user_lines;
      state_reg == PCL_USER |-> load_complete && !config_status_n_oe;
   endproperty
   a_user_lines: assert property (p_user_lines) else $error("user mode lines not high");

   property p_por_hold;
      state_reg == PCL_POR |-> config_status_n_oe;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("status released in power-on");

   property p_load_low;
      state_reg inside {PCL_RESET, PCL_STATUS_HOLD, PCL_LOAD} |-> !load_complete;
   endproperty
   a_load_low: assert property (p_load_low) else $error("load-complete high early");

   property p_req_done;
      $fell(req_s) |-> ##[1:2] !load_complete;
   endproperty
   a_req_done: assert property (p_req_done) else $error("load-complete slow to fall");

   property p_req_status;
      $fell(req_s) |-> ##1 config_status_n_oe;
   endproperty
   a_req_status: assert property (p_req_status) else $error("status slow to fall");

   property p_hold_min;
      $fell(config_status_n_oe) && $past(state_reg) == PCL_STATUS_HOLD
         |-> $past(cnt_reg) >= L_SMIN - 32'h0000_0001;
   endproperty
   a_hold_min: assert property (p_hold_min) else $error("status pulse too short");

   property p_hold_max;
      state_reg == PCL_STATUS_HOLD |-> cnt_reg < L_SMAX;
   endproperty
   a_hold_max: assert property (p_hold_max) else $error("status held too long");

   property p_rise_edge;
      accept |-> pin_q[2] && !$past(pin_q[2]);
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("word taken off a rising edge");

   property p_done_good;
      $rose(load_complete) |-> word_cnt_reg == len_reg && chk_reg == 32'h0000_0000;
   endproperty
   a_done_good: assert property (p_done_good) else $error("load-complete on bad image");

   property p_usr_wait;
      state_reg == PCL_INIT && usr_cnt_reg != 14'h0000 |-> cnt_reg >= L_UW;
   endproperty
   a_usr_wait: assert property (p_usr_wait) else $error("user clock used too soon");

   property p_opt_low;
      state_reg == PCL_INIT && opt_reg |-> !init_done_n;
   endproperty
   a_opt_low: assert property (p_opt_low) else $error("init-done not low");

   property p_phase_step;
      accept && state_next == PCL_LOAD |=> phase_reg == 4'h1;
   endproperty
   a_phase_step: assert property (p_phase_step) else $error("word phase wrong");

   property p_err_status;
      state_reg == PCL_ERROR |-> config_status_n_oe && !load_complete;
   endproperty
   a_err_status: assert property (p_err_status) else $error("error not on status");
endmodule // pcl_loader

/* testbench/pcl_host_model.sv */
// Host model driving request, configuration clock and data
`timescale 1ns/10ps
module pcl_host_model (
   // Clock
   input  wire logic          pclk,
   // Status wire as seen by the host
   input  wire logic          status_line,
   // Pins toward the device
   output logic               config_request_n,
   output logic               config_clock,
   output pcl_pkg::pcl_word_t config_data
);
   import pcl_pkg::*;
   // Idle levels: clock parked low, never floating
   initial begin
      config_request_n = 1'b1;
      config_clock     = 1'b0;
      config_data      = 32'h0000_0000;
   end
   // Request pulse, 400 cycles is the 2 us minimum
   task automatic request();
      config_request_n <= 1'b0;
      repeat (400) @(posedge pclk);
      config_request_n <= 1'b1;
   endtask
   // Wait for status release, then 2 us before clocking
   task automatic start();
      while (status_line !== 1'b1) @(posedge pclk);
      repeat (400) @(posedge pclk);
   endtask
   // Free 48 ns periods of the link clock, well under the rate limit
   task automatic clocks(input int n);
      repeat (n) begin
         #24 config_clock <= 1'b1;
         #24 config_clock <= 1'b0;
      end
   endtask
   // Word set while clock low, held ratio periods; a step later than the
   // previous release, so the bus is never assigned twice in one step
   task automatic send_word(input pcl_word_t w, input int ratio);
      #1 config_data <= w;
      clocks(ratio);
      config_data <= ~w; // Released bus shows the inverse
   endtask
endmodule // pcl_host_model

/* testbench/tb.sv */
// Testbench of the parallel configuration loader
`timescale 1ns/10ps
`include "pcl_cfg.svh"
module tb;
   import pcl_pkg::*;
   logic      pclk, presetn, psel, penable, pwrite, err;
   pcl_addr_t paddr;
   pcl_word_t pwdata, prdata, rd, cdata;
   logic      pready, pslverr, req_n, st_o, st_oe, lc, cclk, idn, um, uclk;
   logic      st_line;
   int        miscompares = 0;
   int        checks_done = 0;
   int        cycles = 0;
   // Pull-up on the shared status wire
   assign st_line = st_oe ? st_o : 1'b1;
   pcl_loader #(.POR_CYCLES(20), .STATUS_MIN_CYCLES(40),
      .INIT_OSC_CYCLES(30), .USR_INIT_EDGES(4)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .config_request_n(req_n),
      .config_status_n_i(st_line), .config_status_n_o(st_o),
      .config_status_n_oe(st_oe), .load_complete(lc), .config_clock(cclk),
      .config_data(cdata), .init_user_clock(uclk), .init_done_n(idn),
      .user_mode(um));
   pcl_host_model i_host (.pclk(pclk), .status_line(st_line),
      .config_request_n(req_n), .config_clock(cclk), .config_data(cdata));
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         conclude();
      end
   end
   task automatic conclude();
      if (miscompares == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // APB transfer; held until pready seen at an edge
   task automatic apb(input logic wr, input pcl_addr_t a, input pcl_word_t d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Bounded wait for a level
   task automatic wait_for(ref logic s, input int lim);
      while (s !== 1'b1 && lim > 0) begin
         @(posedge pclk);
         lim--;
      end
   endtask
   // Full reconfiguration with ratio 3 and four x8 words
   task automatic image(input pcl_word_t last);
      fork
         i_host.request();
         begin
            repeat (120) @(posedge pclk);
            check(st_oe, 1);
            check(lc, 0);
         end
      join
      repeat (30) @(posedge pclk);
      check(st_oe, 1);
      wait_for(st_line, 100);
      check(st_line, 1);
      i_host.start();
      i_host.send_word(32'h0000_0001, 3);
      check(idn, 0);
      i_host.send_word(32'h0000_0012, 3);
      i_host.send_word(32'h0000_0034, 3);
      check(lc, 0);
      i_host.send_word(last, 3);
      repeat (4) @(posedge pclk);
   endtask
   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, uclk} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(st_oe, 1);
      check(lc, 0);
      apb(1'b0, `PCL_OFF_CTRL, 0);
      check(rd, `PCL_CTRL_RST);
      apb(1'b0, `PCL_OFF_LEN, 0);
      check(rd, `PCL_LEN_RST);
      apb(1'b0, 12'h020, 0);
      check(err, 1);
      apb(1'b1, `PCL_OFF_CTRL, 32'h0000_000C);
      apb(1'b1, `PCL_OFF_LEN, 32'h0000_0004);
      apb(1'b0, `PCL_OFF_CTRL, 0);
      check(rd, 32'h0000_000C);
      image(32'h0000_0027);
      check(lc, 1);
      check(um, 0);
      i_host.clocks(2);
      @(posedge pclk);
      wait_for(um, 60);
      check(um, 1);
      check({idn, st_oe, lc}, 3'h5);
      apb(1'b0, `PCL_OFF_COUNT, 0);
      check(rd, 32'h0000_0004);
      image(32'h0000_0055);
      check({lc, st_oe}, 2'h1);
      // User init clock chosen: only its fourth rise ends initialisation
      apb(1'b1, `PCL_OFF_CTRL, 32'h0000_004C);
      image(32'h0000_0027);
      repeat (40) @(posedge pclk);
      repeat (4) begin
         check(um, 0);
         uclk <= 1'b1;
         repeat (4) @(posedge pclk);
         uclk <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      wait_for(um, 8);
      check(um, 1);
      conclude();
   end
endmodule // tb
